/* File: lf_link_model.sv */
// Serial side of the LF link: framing, MSB-first bits and event lines
`timescale 1ns/1ps
`default_nettype none
module lf_link_model
(
	// Clock
	input  wire logic       i_clk,
	// Link lines; events are carrier, code error, sample error, end of message
	output var  logic       o_frame,
	output var  logic       o_bit,
	output var  logic       o_tgl,
	output var  logic [3:0] o_ev
);
	initial
	begin
		o_frame = 1'h0;
		o_bit   = 1'h0;
		o_tgl   = 1'h0;
		o_ev    = 4'h0;
	end
	// Idle data line keeps changing so a stale bit never looks valid
	always @(posedge i_clk)
		if (!o_frame)
			o_bit <= ~o_bit;
	// One bit: data settles well before and after its toggle
	task automatic bit_out(input logic b);
		o_bit <= b;
		repeat (4) @(posedge i_clk);
		o_tgl <= ~o_tgl;
		repeat (4) @(posedge i_clk);
	endtask
	task automatic send_id(input logic [15:0] v);
		for (int k = 15; k >= 0; k--)
			bit_out(v[k]);
	endtask
	task automatic send_byte(input logic [7:0] v);
		for (int k = 7; k >= 0; k--)
			bit_out(v[k]);
	endtask
	task automatic frame(input logic on);
		o_frame <= on;
		repeat (4) @(posedge i_clk);
	endtask
	task automatic pulse(input logic [3:0] m);
		o_ev <= m;
		repeat (4) @(posedge i_clk);
		o_ev <= 4'h0;
		repeat (4) @(posedge i_clk);
	endtask
endmodule // lf_link_model
`default_nettype wire

/* File: lf_rx_data_id_flags.sv */
// LF receive data holding, wake-up ID compare and receive flags, Avalon-MM slave
//
// Local design decision: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "lf_rx_map.svh"
module lf_rx_data_id_flags
(
	// Clock and reset
	input  wire logic        i_clk_sys,
	input  wire logic        i_srst,
	// Avalon-MM slave
	input  wire logic [9:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	input  wire logic [3:0]  i_avs_byteenable,
	output var  logic [31:0] o_avs_readdata,
	output var  logic        o_avs_waitrequest,
	// Demodulator link, asynchronous
	input  wire logic        i_lf_frame,
	input  wire logic        i_lf_bit,
	input  wire logic        i_lf_bit_tgl,
	input  wire logic        i_lf_carrier,
	input  wire logic        i_lf_code_err,
	input  wire logic        i_lf_sample_err,
	input  wire logic        i_lf_eom,
	// Interrupt and wake
	output var  logic        o_irq,
	output var  logic        o_wake
);
	////////////////////////////////////////////////////////////////////////////
	// Declarations
	localparam int NL = 7;          // Number of link inputs
	logic [NL-1:0]          lnk_m;  // First synchroniser stage
	logic [NL-1:0]          lnk_s;  // Second stage, stable
	logic [NL-1:0]          lnk_d;  // Delayed copy for edges
	logic                   frame;  // Frame level
	logic                   rx_bit; // Sampled data bit
	logic                   bit_evt;// One new bit
	logic                   car_evt;// Carrier rise
	logic                   err_evt;// Code or sample error rise
	logic                   eom_evt;// End of message rise
	logic                   frame_rise;
	lf_rx_pkg::rx_state_t   state;
	logic [4:0]             bit_cnt;
	logic [15:0]            id_shift;
	logic [7:0]             byte_shift;
	logic                   frame_bytes; // A byte landed this frame
	logic [7:0]             rx_byte_holding;
	logic [7:0]             wake_id_low;
	logic [7:0]             wake_id_high;
	logic                   byte_unread;
	lf_rx_pkg::flags_t      flags;
	lf_rx_pkg::ctrl_t       ctrl;
	logic [7:0]             irq_stat;
	logic [7:0]             irq_mask;
	logic                   flag_ack_strobe;
	logic                   acc;    // Access taken this edge
	logic                   wr;
	logic                   rd;
	logic [7:0]             idx;
	logic [7:0]             next_shift;
	logic [15:0]            next_id;
	logic                   load_evt;
	logic [7:0]             load_val;
	logic                   id_hit;
	logic                   id_miss;
	lf_rx_pkg::flags_t      set;
	logic [7:0]             set_vec;
	////////////////////////////////////////////////////////////////////////////
	// Functions
	// Compare received ID against the stored halves per select
	function automatic logic id_ok(
		input logic [1:0]  sel,
		input logic [15:0] rid,
		input logic [7:0]  lo,
		input logic [7:0]  hi
	);
		case (lf_rx_pkg::id_sel_t'(sel))
			lf_rx_pkg::SEL_LOW:  id_ok = (rid[7:0] == lo);
			lf_rx_pkg::SEL_HIGH: id_ok = (rid[15:8] == hi);
			lf_rx_pkg::SEL_BOTH: id_ok = (rid == {hi, lo});
			default:             id_ok = 1'b1;
		endcase
	endfunction

	// Flags in register layout
	function automatic logic [7:0] flag_byte(input lf_rx_pkg::flags_t f);
		flag_byte = 8'h00;
		flag_byte[`BIT_RDY] = f.rdy;
		flag_byte[`BIT_ERR] = f.err;
		flag_byte[`BIT_CAR] = f.car;
		flag_byte[`BIT_IDM] = f.idm;
		flag_byte[`BIT_OVF] = f.ovf;
		flag_byte[`BIT_EOM] = f.eom;
	endfunction
	////////////////////////////////////////////////////////////////////////////
	// Link synchroniser
	// Bit and toggle share stages so they stay aligned
	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
		begin
			lnk_m <= '0;
			lnk_s <= '0;
			lnk_d <= '0;
		end
		else
		begin
			lnk_m <= {i_lf_eom, i_lf_sample_err, i_lf_code_err,
				i_lf_carrier, i_lf_bit_tgl, i_lf_bit, i_lf_frame};
			lnk_s <= lnk_m;
			lnk_d <= lnk_s;
		end
	end

	// Events from the stable and delayed stages only
	assign frame      = lnk_s[0];
	assign rx_bit     = lnk_s[1];
	assign frame_rise = lnk_s[0] & ~lnk_d[0];
	assign bit_evt    = (lnk_s[2] ^ lnk_d[2]) & frame;
	assign car_evt    = lnk_s[3] & ~lnk_d[3] & ~frame;
	assign err_evt    = ((lnk_s[4] & ~lnk_d[4]) | (lnk_s[5] & ~lnk_d[5])) & frame;
	assign eom_evt    = lnk_s[6] & ~lnk_d[6] & frame;
	////////////////////////////////////////////////////////////////////////////
	// Bus decode
	assign acc = (i_avs_read | i_avs_write) & ~o_avs_waitrequest;
	assign wr  = acc & i_avs_write & i_avs_byteenable[0];
	assign rd  = acc & i_avs_read;
	assign idx = i_avs_address[9:2];
	////////////////////////////////////////////////////////////////////////////
	// Receive decisions
	// Byte completion, partial byte on error, and ID verdict
	always_comb
	begin
		next_shift = {byte_shift[6:0], rx_bit};
		next_id    = {id_shift[14:0], rx_bit};
		load_evt   = 1'b0;
		load_val   = next_shift;
		id_hit     = 1'b0;
		id_miss    = 1'b0;
		if (state == lf_rx_pkg::ST_DATA && bit_evt && bit_cnt == `BYTE_LAST_BIT)
			load_evt = 1'b1;
		else if (state == lf_rx_pkg::ST_DATA && err_evt && bit_cnt != 5'h00)
		begin
			// Bits before the error still reach software
			load_evt = 1'b1;
			load_val = byte_shift;
		end
		if (state == lf_rx_pkg::ST_ID && bit_evt && bit_cnt == `ID_LAST_BIT)
		begin
			if (id_ok(ctrl.sel, next_id, wake_id_low, wake_id_high))
				id_hit = 1'b1;
			else
				id_miss = 1'b1;
		end
	end
	// Flag set terms
	always_comb
	begin
		set      = '0;
		set.rdy  = load_evt;
		set.ovf  = load_evt & flags.rdy & byte_unread;
		set.idm  = id_hit;
		set.car  = car_evt;
		// Mismatch only counts when error interrupt is on
		set.err  = err_evt | (id_miss & ctrl.err_ie)
			| (eom_evt & frame_bytes);
		set.eom  = eom_evt & frame_bytes & (bit_cnt == 5'h00);
		set_vec  = flag_byte(set);
	end
	////////////////////////////////////////////////////////////////////////////
	// Receive sequencer
	// ID phase first when checking is on, then data bytes
	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
		begin
			state      <= lf_rx_pkg::ST_IDLE;
			bit_cnt    <= 5'h00;
			id_shift   <= 16'h0000;
			byte_shift <= 8'h00;
		end
		else if (!frame)
		begin
			state      <= lf_rx_pkg::ST_IDLE;
			bit_cnt    <= 5'h00;
			byte_shift <= 8'h00;
		end
		else
		begin
			case (state)
				lf_rx_pkg::ST_IDLE:
				begin
					// Select off skips the ID phase
					if (frame_rise)
						state <= (ctrl.sel == 2'h0) ? lf_rx_pkg::ST_DATA
							: lf_rx_pkg::ST_ID;
					bit_cnt <= 5'h00;
				end
				lf_rx_pkg::ST_ID:
				begin
					if (bit_evt)
					begin
						id_shift <= next_id;
						bit_cnt  <= bit_cnt + 5'h01;
					end
					// A rejected ID drops the rest of the frame
					if (id_hit)
					begin
						state   <= lf_rx_pkg::ST_DATA;
						bit_cnt <= 5'h00;
					end
					else if (id_miss)
						state <= lf_rx_pkg::ST_DROP;
				end
				lf_rx_pkg::ST_DATA:
				begin
					if (load_evt)
						bit_cnt <= 5'h00;
					else if (bit_evt)
						bit_cnt <= bit_cnt + 5'h01;
					// Start each byte empty so a partial one carries no stale bits
					if (load_evt)
						byte_shift <= 8'h00;
					else if (bit_evt)
						byte_shift <= next_shift;
				end
				lf_rx_pkg::ST_DROP:
					bit_cnt <= 5'h00;
				default:
					state <= lf_rx_pkg::ST_IDLE;
			endcase
		end
	end
	// Remembers a byte landed, for end-of-message
	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst || frame_rise)
			frame_bytes <= 1'b0;
		else if (load_evt)
			frame_bytes <= 1'b1;
	end
	////////////////////////////////////////////////////////////////////////////
	// Holding and ID registers
	// Holding register: loaded only by the receiver
	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
			rx_byte_holding <= `RST_BYTE;
		else if (load_evt)
			rx_byte_holding <= load_val;
	end
	// Unread marker; a load in the read cycle wins
	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
			byte_unread <= 1'b0;
		else if (load_evt)
			byte_unread <= 1'b1;
		else if (rd && idx == `IDX_RX_BYTE)
			byte_unread <= 1'b0;
	end

	// ID halves and control, software written
	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
		begin
			wake_id_low  <= `RST_ID;
			wake_id_high <= `RST_ID;
			ctrl         <= '0;
			irq_mask     <= `RST_MASK;
		end
		else if (wr)
		begin
			case (idx)
				`IDX_ID_LOW:   wake_id_low  <= i_avs_writedata[7:0];
				`IDX_ID_HIGH:  wake_id_high <= i_avs_writedata[7:0];
				`IDX_CTRL:     ctrl         <= i_avs_writedata[3:0];
				`IDX_IRQ_MASK: irq_mask     <= i_avs_writedata[7:0];
				default:       ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Flags and acknowledge
	// Strobe lives one cycle; a zero write leaves it low
	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
			flag_ack_strobe <= 1'b0;
		else
			flag_ack_strobe <= wr && idx == `IDX_FLAGS
				&& i_avs_writedata[`BIT_ACK];
	end
	// Clear by strobe, set wins in the same cycle
	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
			flags <= '0;
		else if (flag_ack_strobe)
			flags <= set;
		else
			flags <= flags | set;
	end
	////////////////////////////////////////////////////////////////////////////
	// Interrupts
	// Sticky status; a read clears only the bits it reported, so an event
	// landing between capture and take is not lost; set wins
	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
			irq_stat <= 8'h00;
		else if (rd && idx == `IDX_IRQ_STAT)
			irq_stat <= (irq_stat & ~o_avs_readdata[7:0]) | set_vec;
		else
			irq_stat <= irq_stat | set_vec;
	end
	// Level interrupt from unmasked status
	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
			o_irq <= 1'b0;
		else
			o_irq <= |(irq_stat & irq_mask);
	end
	// Wake pulse on accepted ID or enabled error
	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
			o_wake <= 1'b0;
		else
			o_wake <= (id_hit & ctrl.id_ie)
				| (set.err & ctrl.err_ie);
	end

	////////////////////////////////////////////////////////////////////////////
	// Bus response
	// One wait cycle per access keeps read data registered
	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
			o_avs_waitrequest <= 1'b1;
		else
			o_avs_waitrequest <= ~((i_avs_read | i_avs_write) & o_avs_waitrequest);
	end
	// Read data captured in the wait cycle; unmapped reads zero
	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
			o_avs_readdata <= 32'h0000_0000;
		else if (i_avs_read && o_avs_waitrequest)
		begin
			case (idx)
				`IDX_FLAGS:    o_avs_readdata <= {24'h0, flag_byte(flags)};
				`IDX_RX_BYTE:  o_avs_readdata <= {24'h0, rx_byte_holding};
				`IDX_ID_LOW:   o_avs_readdata <= {24'h0, wake_id_low};
				`IDX_ID_HIGH:  o_avs_readdata <= {24'h0, wake_id_high};
				`IDX_IRQ_STAT: o_avs_readdata <= {24'h0, irq_stat};
				`IDX_IRQ_MASK: o_avs_readdata <= {24'h0, irq_mask};
				`IDX_CTRL:     o_avs_readdata <= {28'h0, ctrl};
				default:       o_avs_readdata <= 32'h0000_0000;
			endcase
		end
	end
endmodule // lf_rx_data_id_flags
`default_nettype wire

/* File: lf_rx_map.svh */
// Register offsets, field positions, reset values and counts of the LF receive block
`ifndef LF_RX_MAP_SVH
`define LF_RX_MAP_SVH
// Register indices; byte address is four times the index
`define IDX_FLAGS     8'h24
`define IDX_RX_BYTE   8'h25
`define IDX_ID_LOW    8'h26
`define IDX_ID_HIGH   8'h27
`define IDX_IRQ_STAT  8'h30
`define IDX_IRQ_MASK  8'h31
`define IDX_CTRL      8'h32
// Flag and interrupt bit positions
`define BIT_ACK       0
`define BIT_EOM       2
`define BIT_OVF       3
`define BIT_IDM       4
`define BIT_CAR       5
`define BIT_ERR       6
`define BIT_RDY       7
// Control register fields
`define POS_SEL       0
`define POS_ID_IE     2
`define POS_ERR_IE    3
// Reset values
`define RST_BYTE      8'h00
`define RST_ID        8'h00
`define RST_MASK      8'h00
// Frame counts
`define ID_LAST_BIT   5'h0F
`define BYTE_LAST_BIT 5'h07
`endif

/* File: lf_rx_monitor.sv */
// Port checker of the LF receive data, ID and flag block
`timescale 1ns/1ps
`default_nettype none
module lf_rx_monitor
(
	// Clock and reset
	input wire logic        i_clk_sys,
	input wire logic        i_srst,
	// Bus
	input wire logic [9:0]  i_avs_address,
	input wire logic        i_avs_read,
	input wire logic        i_avs_write,
	input wire logic [31:0] o_avs_readdata,
	input wire logic        o_avs_waitrequest,
	// Interrupt and wake
	input wire logic        o_irq,
	input wire logic        o_wake
);
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (i_srst);
	// Request present, read answered, word index
	wire       req = i_avs_read | i_avs_write;
	wire       ans = i_avs_read & !o_avs_waitrequest;
	wire [7:0] idx = i_avs_address[9:2];
	////////////////////////////////////////
	a_wait_one: assert property ($rose(req) |=> !o_avs_waitrequest)
		else $error("request not answered after one wait cycle");
	a_wait_short: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
		else $error("answer stood longer than one cycle");
	a_wait_cause: assert property (!o_avs_waitrequest |-> $past(req))
		else $error("answer without a request");
	a_read_upper: assert property (ans |-> o_avs_readdata[31:8] == 24'h000000)
		else $error("upper read bits not zero");
	a_ack_zero: assert property (ans && idx == 8'h24 |-> !o_avs_readdata[0])
		else $error("ack bit read as one");
	a_data_hold: assert property ($changed(o_avs_readdata) |-> ans)
		else $error("read data moved outside an answer");
	a_reset_quiet: assert property ($past(i_srst) |-> o_avs_waitrequest && !o_irq
		&& !o_wake && o_avs_readdata == 32'h0)
		else $error("outputs not quiet after reset");
	a_wake_pulse: assert property (o_wake |=> !o_wake)
		else $error("wake longer than one cycle");
	a_unmapped_zero: assert property (ans && idx == 8'h00 |-> o_avs_readdata == 32'h0)
		else $error("unmapped read not zero");
	c_read_rx: cover property (ans && idx == 8'h25);
	c_irq: cover property (o_irq);
	c_wake: cover property (o_wake);
endmodule // lf_rx_monitor
bind lf_rx_data_id_flags lf_rx_monitor i_lf_rx_monitor
(
	.i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_avs_address(i_avs_address),
	.i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata),
	.o_avs_waitrequest(o_avs_waitrequest), .o_irq(o_irq), .o_wake(o_wake)
);
`default_nettype wire

/* File: lf_rx_pkg.sv */
// Types shared by the LF receive data, ID and flag block
`default_nettype none
package lf_rx_pkg;
	// Six receive flags
	typedef struct packed {
		logic rdy;
		logic err;
		logic car;
		logic idm;
		logic ovf;
		logic eom;
	} flags_t;
	// Software control settings
	typedef struct packed {
		logic       err_ie;
		logic       id_ie;
		logic [1:0] sel;
	} ctrl_t;
	// Compare kinds of the ID select field
	typedef enum logic [1:0] {
		SEL_OFF  = 2'h0,
		SEL_LOW  = 2'h1,
		SEL_HIGH = 2'h2,
		SEL_BOTH = 2'h3
	} id_sel_t;
	// Receive sequencer states
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ID,
		ST_DATA,
		ST_DROP
	} rx_state_t;
endpackage
`default_nettype wire

/* File: testbench.sv */
// Self-checking bench of the LF receive data, ID and flag block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        clk   = 1'h0;
	logic        srst  = 1'h1;
	logic [9:0]  addr  = 10'h000;
	logic        rd    = 1'h0;
	logic        wr    = 1'h0;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  be    = 4'hF;
	logic [31:0] rdata;
	logic [31:0] r;
	logic        waitr;
	logic        frm;
	logic        lbit;
	logic        tgl;
	logic [3:0]  ev;
	logic        irq;
	logic        wake;
	logic [7:0]  idl;
	logic [7:0]  idh;
	logic [7:0]  d;
	logic [7:0]  ef;
	int          bad_count;
	int          check_count;
	int          cyc;
	int          wake_n;
	int          ew;
	// 250 MHz
	initial
		forever #2 clk = ~clk;
	lf_rx_data_id_flags i_lf_rx_data_id_flags
	(
		.i_clk_sys(clk), .i_srst(srst), .i_avs_address(addr), .i_avs_read(rd),
		.i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be),
		.o_avs_readdata(rdata), .o_avs_waitrequest(waitr), .i_lf_frame(frm),
		.i_lf_bit(lbit), .i_lf_bit_tgl(tgl), .i_lf_carrier(ev[0]), .i_lf_code_err(ev[1]),
		.i_lf_sample_err(ev[2]), .i_lf_eom(ev[3]), .o_irq(irq), .o_wake(wake)
	);
	lf_link_model i_lf_link_model
	(
		.i_clk(clk), .o_frame(frm), .o_bit(lbit), .o_tgl(tgl), .o_ev(ev)
	);
	////////////////////////////////////////
	task automatic summarize;
		if (bad_count == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
		end
	endtask
	// One bus access, held until the edge that samples waitrequest low
	task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] v);
		wr    <= w;
		rd    <= ~w;
		addr  <= {idx, 2'h0};
		wdata <= {24'h000000, v};
		do
			@(posedge clk);
		while (waitr !== 1'h0);
		r = rdata;
		wr <= 1'h0;
		rd <= 1'h0;
		@(posedge clk);
	endtask
	task automatic rdc(input logic [7:0] idx, input logic [7:0] e);
		bus(1'h0, idx, 8'h00);
		check(r, {24'h000000, e});
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Whole frame; the link lags a few cycles behind the pins
	task automatic msg(input logic id_on, input logic [15:0] id, input logic [7:0] v);
		i_lf_link_model.frame(1'h1);
		if (id_on)
			i_lf_link_model.send_id(id);
		i_lf_link_model.send_byte(v);
		i_lf_link_model.frame(1'h0);
		idle(8);
	endtask
	////////////////////////////////////////
	always @(posedge clk)
		if (wake === 1'h1)
			wake_n++;
	// Hang guard, far above the roughly 1500 cycles the run needs
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			bad_count++;
			summarize();
		end
	end
	initial
	begin
		void'($urandom(2));
		repeat (2) @(posedge clk);
		srst <= 1'h0;
		@(posedge clk);
		for (int k = 36; k < 40; k++)
			rdc(8'(k), 8'h00);
		bus(1'h1, 8'h25, 8'hA5);
		rdc(8'h25, 8'h00);
		rdc(8'h3F, 8'h00);
		idl = 8'($urandom);
		idh = 8'($urandom);
		bus(1'h1, 8'h26, idl);
		bus(1'h1, 8'h27, idh);
		rdc(8'h26, idl);
		rdc(8'h27, idh);
		// A write without the low byte lane must not land
		be <= 4'hE;
		bus(1'h1, 8'h26, ~idl);
		be <= 4'hF;
		rdc(8'h26, idl);
		bus(1'h1, 8'h31, 8'h90);
		// Every select kind; only the low ID byte matches
		for (int s = 0; s < 4; s++)
		begin
			bus(1'h1, 8'h32, 8'(4 + s));
			d = 8'($urandom);
			msg(s != 0, {~idh, idl}, d);
			ef = (s == 0) ? 8'h80 : ((s == 1) ? 8'h90 : 8'h00);
			ew += (s == 1);
			rdc(8'h24, ef);
			check(32'(wake_n), 32'(ew));
			check({31'h0, irq}, 32'(s < 2));
			if (s < 2)
				rdc(8'h25, d);
			rdc(8'h30, ef);
			bus(1'h1, 8'h24, 8'h01);
			idle(2);
			check({31'h0, irq}, 32'h0);
		end
		// Two bytes unread, then end of message
		bus(1'h1, 8'h32, 8'h0B);
		i_lf_link_model.frame(1'h1);
		i_lf_link_model.send_id({idh, idl});
		i_lf_link_model.send_byte(d);
		d = 8'($urandom);
		i_lf_link_model.send_byte(d);
		i_lf_link_model.pulse(4'h8);
		i_lf_link_model.frame(1'h0);
		idle(8);
		ew++;
		rdc(8'h24, 8'hDC);
		check(32'(wake_n), 32'(ew));
		rdc(8'h25, d);
		bus(1'h1, 8'h24, 8'h00);
		i_lf_link_model.pulse(4'h1);
		idle(8);
		rdc(8'h24, 8'hFC);
		rdc(8'h30, 8'hFC);
		bus(1'h1, 8'h24, 8'h01);
		rdc(8'h24, 8'h00);
		// Mismatch with error enable, first masked then unmasked
		msg(1'h1, {idh, ~idl}, d);
		ew++;
		rdc(8'h24, 8'h40);
		check(32'(wake_n), 32'(ew));
		check({31'h0, irq}, 32'h0);
		bus(1'h1, 8'h31, 8'h40);
		idle(3);
		check({31'h0, irq}, 32'h1);
		// Partial bytes on a code error, then on a sampling error
		bus(1'h1, 8'h24, 8'h01);
		bus(1'h1, 8'h32, 8'h08);
		d = 8'($urandom);
		i_lf_link_model.frame(1'h1);
		for (int k = 2; k >= 0; k--)
			i_lf_link_model.bit_out(d[k]);
		i_lf_link_model.pulse(4'h2);
		rdc(8'h25, {5'h00, d[2:0]});
		for (int k = 7; k >= 6; k--)
			i_lf_link_model.bit_out(d[k]);
		i_lf_link_model.pulse(4'h4);
		i_lf_link_model.frame(1'h0);
		idle(8);
		ew += 2;
		rdc(8'h24, 8'hC0);
		check(32'(wake_n), 32'(ew));
		rdc(8'h25, {6'h00, d[7:6]});
		summarize();
	end
endmodule // testbench
`default_nettype wire
